// ==== core/sdi_top.sv ====
// Diagnostic flags, monitor setup and interrupt pin
//
// Chosen here: the Avalon-MM slave port and the register addresses.
`include "sdi_consts.svh"
`default_nettype none
module sdi_top #(
    parameter int ILIM_CYCLES = `SDI_ILIM_CYC,
    parameter int SC_CYCLES   = `SDI_SC_CYC,
    parameter int EXT_NOM_W   = `SDI_EXT_NOM_W
) (
    // Clock and reset
    input  wire logic                  clock,
    input  wire logic                  sys_rst,
    // Register bus
    input  wire logic [7:0]            avs_address,
    input  wire logic                  avs_read,
    input  wire logic                  avs_write,
    input  wire logic [31:0]           avs_writedata,
    input  wire logic [3:0]            avs_byteenable,
    output var  logic [31:0]           avs_readdata,
    output var  logic                  avs_waitrequest,
    // Comparator and detector pins
    input  wire logic [1:0]            step_down_ilim_in,
    input  wire logic                  step_up_ilim_in,
    input  wire logic [2:0]            short_in,
    input  wire logic                  thermal_warn_in,
    input  wire logic                  thermal_sd_in,
    input  wire logic                  supply_ov_in,
    input  wire logic [5:0]            rail_under_in,
    input  wire logic [5:0]            rail_over_in,
    input  wire logic                  sync_clk_present_in,
    input  wire logic                  uvlo_in,
    // Same-clock inputs from converter control and measurement
    input  wire logic [2:0]            conv_enabled,
    input  wire logic                  meas_done,
    // Interrupt and safe-state outputs
    output var  logic                  irq_out_n,
    output var  logic [2:0]            conv_short_off,
    output var  logic                  all_conv_off,
    output var  logic                  gpo_force_low,
    output var  logic                  device_restart,
    // Monitor configuration to comparators
    output var  logic                  ov_uv_select,
    output var  logic [5:0]            monitor_enable_reg,
    output var  sdi_pkg::sdi_band_t    step_down_band_sel_0,
    output var  sdi_pkg::sdi_band_t    step_down_band_sel_1,
    output var  logic [1:0]            step_up_nominal_sel,
    output var  sdi_pkg::sdi_band_t    step_up_band_sel,
    output var  logic                  analog_supply_nominal_sel,
    output var  sdi_pkg::sdi_ana_band_t analog_supply_band_sel,
    output var  logic [EXT_NOM_W-1:0]  ext_monitor_nominal_sel_a,
    output var  logic [EXT_NOM_W-1:0]  ext_monitor_nominal_sel_b,
    output var  sdi_pkg::sdi_band_t    ext_monitor_band_sel_a,
    output var  sdi_pkg::sdi_band_t    ext_monitor_band_sel_b
);
    import sdi_pkg::*;

    localparam int SW  = 23;
    localparam int NF  = `SDI_NFLAG;
    localparam int ICW = $clog2(ILIM_CYCLES + 1);
    localparam int SCW = $clog2(SC_CYCLES + 1);

    // Pin synchronisers: two flops per bit, only the second is read
    wire  [SW-1:0] raw_in;
    logic [SW-1:0] meta_r;
    logic [SW-1:0] sync_r;
    assign raw_in = {uvlo_in, sync_clk_present_in, rail_over_in, rail_under_in,
                     supply_ov_in, thermal_sd_in, thermal_warn_in, short_in,
                     step_up_ilim_in, step_down_ilim_in};

    genvar gi;
    generate
        for (gi = 0; gi < SW; gi++) begin : g_sync
            always_ff @(posedge clock or posedge sys_rst) begin
                if (sys_rst) begin
                    meta_r[gi] <= 1'b0;
                    sync_r[gi] <= 1'b0;
                end else begin
                    meta_r[gi] <= raw_in[gi];
                    sync_r[gi] <= meta_r[gi];
                end
            end
        end
    endgenerate

    wire [1:0] dn_ilim_s = sync_r[1:0];
    wire       up_ilim_s = sync_r[2];
    wire [2:0] short_s   = sync_r[5:3];
    wire       twarn_s   = sync_r[6];
    wire       tsd_s     = sync_r[7];
    wire       ovp_s     = sync_r[8];
    wire [5:0] under_s   = sync_r[14:9];
    wire [5:0] over_s    = sync_r[20:15];
    wire       clk_s     = sync_r[21];
    wire       uvlo_s    = sync_r[22];

    // Registers
    logic [31:0]   cfg_r;
    logic [31:0]   lvl_r;
    logic [31:0]   mask_r;
    logic [31:0]   fmask_r;
    logic [NF-1:0] flags_r;
    logic [NF-1:0] flags_nxt;
    logic          soft_rst_r;
    logic          uvlo_prev_r;
    logic          clk_prev_r;
    logic [1:0]    dn_ilim_db_r;
    logic          up_ilim_prev_r;
    logic [1:0]    dn_ilim_prev_r;
    logic [2:0]    sc_hit_r;
    logic          twarn_prev_r;
    logic          tsd_prev_r;
    logic          ovp_prev_r;
    logic [5:0]    good_prev_r;
    logic [5:0]    rise_dir_r;
    sdi_bus_t      bus_r;
    sdi_bus_t      bus_nxt;

    // Bus decode
    wire        bus_req   = avs_read | avs_write;
    wire        bus_take  = (bus_r == SDI_ANS) & bus_req;
    wire        wr_go     = bus_take & avs_write;
    wire [31:0] wmask     = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}},
                             {8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};
    wire [31:0] wdm       = avs_writedata & wmask;
    wire        hit_cfg   = avs_address == `SDI_OFS_CFG;
    wire        hit_lvl   = avs_address == `SDI_OFS_LEVEL;
    wire        hit_flags = avs_address == `SDI_OFS_FLAGS;
    wire        hit_mask  = avs_address == `SDI_OFS_MASK;
    wire        hit_fmask = avs_address == `SDI_OFS_FALL_MASK;
    wire        hit_stat  = avs_address == `SDI_OFS_STATUS;

    // Lockout or software reset restores defaults
    wire regs_clear = uvlo_s | soft_rst_r;
    wire sw_rst_req = wr_go & hit_cfg & wdm[`SDI_CFG_SWRST];

    // Step-down current limit debounce
    logic [ICW-1:0] ilim_cnt_r [2];
    generate
        for (gi = 0; gi < 2; gi++) begin : g_ilim
            always_ff @(posedge clock or posedge sys_rst) begin
                if (sys_rst) begin
                    ilim_cnt_r[gi]   <= '0;
                    dn_ilim_db_r[gi] <= 1'b0;
                end else if (!dn_ilim_s[gi]) begin
                    ilim_cnt_r[gi]   <= '0;
                    dn_ilim_db_r[gi] <= 1'b0;
                end else if (ilim_cnt_r[gi] == ICW'(ILIM_CYCLES - 1)) begin
                    dn_ilim_db_r[gi] <= 1'b1;
                end else begin
                    ilim_cnt_r[gi] <= ilim_cnt_r[gi] + 1'b1;
                end
            end
        end
    endgenerate

    // Short: detector high for the whole window while enabled
    logic [SCW-1:0] sc_cnt_r [3];
    wire  [2:0]     sc_evt;
    generate
        for (gi = 0; gi < 3; gi++) begin : g_sc
            assign sc_evt[gi] = (sc_cnt_r[gi] == SCW'(SC_CYCLES - 1)) & ~sc_hit_r[gi];
            always_ff @(posedge clock or posedge sys_rst) begin
                if (sys_rst) begin
                    sc_cnt_r[gi] <= '0;
                    sc_hit_r[gi] <= 1'b0;
                end else if (!(short_s[gi] && conv_enabled[gi])) begin
                    sc_cnt_r[gi] <= '0;
                    sc_hit_r[gi] <= 1'b0;
                end else if (sc_cnt_r[gi] == SCW'(SC_CYCLES - 1)) begin
                    sc_hit_r[gi] <= 1'b1;
                end else begin
                    sc_cnt_r[gi] <= sc_cnt_r[gi] + 1'b1;
                end
            end
        end
    endgenerate

    // Rail validity and edges
    wire [5:0] mon_en    = cfg_r[`SDI_CFG_MON_HI:`SDI_CFG_MON_LO];
    wire [5:0] rail_act  = mon_en & {3'b111, conv_enabled};
    wire [5:0] rail_ok   = ~under_s & ~(over_s & {6{cfg_r[`SDI_CFG_OVUV]}});
    wire [5:0] good_edge = rail_act & (rail_ok ^ good_prev_r);
    wire [5:0] good_live = rail_act & rail_ok;

    // Event sources
    wire [NF-1:0] set_evt;
    assign set_evt[1:0]  = dn_ilim_db_r & ~dn_ilim_prev_r;
    assign set_evt[2]    = up_ilim_s & ~up_ilim_prev_r;
    assign set_evt[5:3]  = sc_evt;
    assign set_evt[6]    = twarn_s & ~twarn_prev_r;
    assign set_evt[7]    = tsd_s & ~tsd_prev_r;
    assign set_evt[8]    = ovp_s & ~ovp_prev_r;
    assign set_evt[14:9] = good_edge;
    assign set_evt[15]   = cfg_r[`SDI_CFG_CLKDET] & (clk_s ^ clk_prev_r);
    assign set_evt[16]   = meas_done;
    assign set_evt[17]   = (uvlo_prev_r & ~uvlo_s) | soft_rst_r;

    // Clears of limit, thermal and overvoltage flags refused while the cause holds
    wire [NF-1:0] hold_cond = {9'h000, ovp_s, tsd_s, twarn_s, 3'b000,
                               up_ilim_s, dn_ilim_db_r};
    wire [NF-1:0] clr_req   = (wr_go & hit_flags) ? wdm[NF-1:0] : '0;
    wire [NF-1:0] clr_eff   = clr_req & ~hold_cond;

    always_comb begin
        if (regs_clear) begin
            flags_nxt = set_evt & NF'(1 << `SDI_F_RESET);
        end else begin
            flags_nxt = set_evt | (flags_r & ~clr_eff);
        end
    end

    // Interrupt enables; rails use the mask of their last edge
    wire [5:0]    rail_en = (rise_dir_r & ~mask_r[14:9]) | (~rise_dir_r & ~fmask_r[5:0]);
    wire [NF-1:0] irq_en  = (~mask_r[NF-1:0] & ~NF'(32'h0000_7E00)) | `SDI_UNMASKABLE
                            | {3'b000, rail_en, 9'h000};
    wire          irq_any = |(flags_r & irq_en);

    // Group flags and read mux
    wire grp_dn   = |{flags_r[1:0], flags_r[4:3], flags_r[10:9]};
    wire grp_up   = |{flags_r[2], flags_r[5], flags_r[11]};
    wire grp_diag = |flags_r[14:12];
    wire [31:0] stat_word = {16'h0000, clk_s, good_live, ovp_s, tsd_s, twarn_s,
                             short_s, up_ilim_s, dn_ilim_db_r};
    wire [31:0] rd_mux =
        hit_cfg   ? (cfg_r & 32'h0000_00FF) :
        hit_lvl   ? lvl_r :
        hit_flags ? {11'h000, grp_diag, grp_up, grp_dn, flags_r} :
        hit_mask  ? mask_r :
        hit_fmask ? fmask_r :
        hit_stat  ? stat_word : 32'h0000_0000;

    // Bus handshake: one wait cycle
    always_comb begin
        unique case (bus_r)
            SDI_IDLE: bus_nxt = bus_req ? SDI_ANS : SDI_IDLE;
            SDI_ANS:  bus_nxt = SDI_IDLE;
            default:  bus_nxt = SDI_IDLE;
        endcase
    end

    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            bus_r           <= SDI_IDLE;
            avs_waitrequest <= 1'b1;
            avs_readdata    <= 32'h0000_0000;
        end else begin
            bus_r           <= bus_nxt;
            avs_waitrequest <= ~((bus_r == SDI_IDLE) & bus_req);
            if ((bus_r == SDI_IDLE) && avs_read) begin
                avs_readdata <= rd_mux;
            end
        end
    end

    // Configuration registers
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            cfg_r   <= `SDI_CFG_RST;
            lvl_r   <= `SDI_LVL_RST;
            mask_r  <= `SDI_MASK_RST;
            fmask_r <= `SDI_FMASK_RST;
        end else if (regs_clear) begin
            cfg_r   <= `SDI_CFG_RST;
            lvl_r   <= `SDI_LVL_RST;
            mask_r  <= `SDI_MASK_RST;
            fmask_r <= `SDI_FMASK_RST;
        end else if (wr_go) begin
            if (hit_cfg) cfg_r <= ((cfg_r & ~wmask) | wdm) & 32'h0000_00FF;
            if (hit_lvl) lvl_r <= ((lvl_r & ~wmask) | wdm) & 32'h007F_FFFF;
            if (hit_mask) mask_r <= ((mask_r & ~wmask) | wdm) & 32'h0003_FE47;
            if (hit_fmask) fmask_r <= ((fmask_r & ~wmask) | wdm) & 32'h0000_003F;
        end
    end

    // Flags and edge history
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            flags_r        <= '0;
            soft_rst_r     <= 1'b0;
            uvlo_prev_r    <= 1'b0;
            clk_prev_r     <= 1'b0;
            dn_ilim_prev_r <= 2'b00;
            up_ilim_prev_r <= 1'b0;
            twarn_prev_r   <= 1'b0;
            tsd_prev_r     <= 1'b0;
            ovp_prev_r     <= 1'b0;
            good_prev_r    <= 6'h00;
            rise_dir_r     <= 6'h00;
        end else begin
            flags_r        <= flags_nxt;
            soft_rst_r     <= sw_rst_req;
            uvlo_prev_r    <= uvlo_s;
            clk_prev_r     <= clk_s;
            dn_ilim_prev_r <= dn_ilim_db_r;
            up_ilim_prev_r <= up_ilim_s;
            twarn_prev_r   <= twarn_s;
            tsd_prev_r     <= tsd_s;
            ovp_prev_r     <= ovp_s;
            // Inactive rails track silently so enabling raises no false edge
            good_prev_r    <= rail_ok;
            rise_dir_r     <= (rise_dir_r & ~good_edge) | (rail_ok & good_edge);
        end
    end

    // Outputs
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            irq_out_n      <= 1'b1;
            conv_short_off <= 3'b000;
            all_conv_off   <= 1'b0;
            gpo_force_low  <= 1'b0;
            device_restart <= 1'b0;
        end else begin
            irq_out_n      <= ~irq_any;
            conv_short_off <= flags_nxt[5:3];
            all_conv_off   <= flags_nxt[7] | flags_nxt[8] | regs_clear;
            gpo_force_low  <= flags_nxt[7] | flags_nxt[8] | regs_clear;
            device_restart <= regs_clear;
        end
    end

    // Comparator configuration
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            ov_uv_select              <= 1'b0;
            monitor_enable_reg        <= 6'h00;
            step_down_band_sel_0      <= 2'b00;
            step_down_band_sel_1      <= 2'b00;
            step_up_nominal_sel       <= 2'b00;
            step_up_band_sel          <= 2'b00;
            analog_supply_nominal_sel <= 1'b0;
            analog_supply_band_sel    <= SDI_ANA_4PCT;
            ext_monitor_nominal_sel_a <= '0;
            ext_monitor_nominal_sel_b <= '0;
            ext_monitor_band_sel_a    <= 2'b00;
            ext_monitor_band_sel_b    <= 2'b00;
        end else begin
            ov_uv_select              <= cfg_r[`SDI_CFG_OVUV];
            monitor_enable_reg        <= rail_act;
            step_down_band_sel_0      <= lvl_r[`SDI_LVL_B0BAND_LO +: 2];
            step_down_band_sel_1      <= lvl_r[`SDI_LVL_B1BAND_LO +: 2];
            step_up_nominal_sel       <= lvl_r[`SDI_LVL_UPNOM_LO +: 2];
            step_up_band_sel          <= lvl_r[`SDI_LVL_UPBAND_LO +: 2];
            analog_supply_nominal_sel <= lvl_r[`SDI_LVL_ANANOM];
            // Reserved code 3 falls back to the widest band
            analog_supply_band_sel    <= (lvl_r[`SDI_LVL_ANBAND_LO +: 2] == 2'b11) ?
                                         SDI_ANA_10PCT :
                                         sdi_ana_band_t'(lvl_r[`SDI_LVL_ANBAND_LO +: 2]);
            ext_monitor_nominal_sel_a <= lvl_r[`SDI_LVL_EANOM_LO +: EXT_NOM_W];
            ext_monitor_nominal_sel_b <= lvl_r[`SDI_LVL_EBNOM_LO +: EXT_NOM_W];
            ext_monitor_band_sel_a    <= lvl_r[`SDI_LVL_EABAND_LO +: 2];
            ext_monitor_band_sel_b    <= lvl_r[`SDI_LVL_EBBAND_LO +: 2];
        end
    end

endmodule
`default_nettype wire

// ==== core/sdi_consts.svh ====
// Register map, fields, reset values and timing counts
`ifndef SDI_CONSTS_SVH
`define SDI_CONSTS_SVH

// Register byte offsets
`define SDI_OFS_CFG         8'h00
`define SDI_OFS_LEVEL       8'h04
`define SDI_OFS_FLAGS       8'h08
`define SDI_OFS_MASK        8'h0C
`define SDI_OFS_FALL_MASK   8'h10
`define SDI_OFS_STATUS      8'h14

// CFG fields
`define SDI_CFG_OVUV        0
`define SDI_CFG_MON_LO      1
`define SDI_CFG_MON_HI      6
`define SDI_CFG_CLKDET      7
`define SDI_CFG_SWRST       8

// LEVEL fields
`define SDI_LVL_B0BAND_LO   0
`define SDI_LVL_B1BAND_LO   2
`define SDI_LVL_UPNOM_LO    4
`define SDI_LVL_UPBAND_LO   6
`define SDI_LVL_ANANOM      8
`define SDI_LVL_ANBAND_LO   9
`define SDI_LVL_EANOM_LO    11
`define SDI_LVL_EBNOM_LO    15
`define SDI_LVL_EABAND_LO   19
`define SDI_LVL_EBBAND_LO   21

// Flag vector positions
`define SDI_F_DN_ILIM       0
`define SDI_F_UP_ILIM       2
`define SDI_F_DN_SC         3
`define SDI_F_UP_SC         5
`define SDI_F_TWARN         6
`define SDI_F_TSD           7
`define SDI_F_OVP           8
`define SDI_F_GOOD          9
`define SDI_F_SYNC          15
`define SDI_F_MEAS          16
`define SDI_F_RESET         17
`define SDI_F_GRP           18
`define SDI_NFLAG           18

// Reset values
`define SDI_CFG_RST         32'h0000_0000
`define SDI_LVL_RST         32'h0000_0000
`define SDI_MASK_RST        32'h0000_0000
`define SDI_FMASK_RST       32'h0000_0000
`define SDI_UNMASKABLE      18'h0_01B8

// Timing
`define SDI_CLK_MHZ         100
`define SDI_ILIM_DEB_US     20
`define SDI_SC_DEB_MS       1
`define SDI_ILIM_CYC        (`SDI_ILIM_DEB_US * `SDI_CLK_MHZ)
`define SDI_SC_CYC          (`SDI_SC_DEB_MS * 1000 * `SDI_CLK_MHZ)

// External nominal code width
`define SDI_EXT_NOM_W       4

`endif

// ==== core/sdi_pkg.sv ====
// Types shared by the supply diagnostic block
`default_nettype none
package sdi_pkg;
    typedef enum logic [1:0] {
        SDI_IDLE = 2'b01,
        SDI_ANS  = 2'b10
    } sdi_bus_t;
    typedef enum logic [1:0] {
        SDI_ANA_4PCT  = 2'b00,
        SDI_ANA_5PCT  = 2'b01,
        SDI_ANA_10PCT = 2'b10
    } sdi_ana_band_t;
    typedef logic [1:0] sdi_band_t;
endpackage
`default_nettype wire

// ==== testbench/sdi_checker.sv ====
// Port checker for the supply diagnostic block
`default_nettype none
module sdi_checker #(
    parameter int SC_CYCLES = 20
) (
    // Clock and reset
    input wire logic       clock,
    input wire logic       sys_rst,
    // Register bus
    input wire logic       avs_read,
    input wire logic       avs_write,
    input wire logic       avs_waitrequest,
    // Detectors and converter state
    input wire logic [2:0] short_in,
    input wire logic       thermal_sd_in,
    input wire logic       supply_ov_in,
    input wire logic       uvlo_in,
    input wire logic [2:0] conv_enabled,
    // Outputs
    input wire logic       irq_out_n,
    input wire logic [2:0] conv_short_off,
    input wire logic       all_conv_off,
    input wire logic       gpo_force_low,
    input wire logic       device_restart,
    input wire logic [5:0] monitor_enable_reg
);
    default clocking @(posedge clock); endclocking
    default disable iff (sys_rst);
    int sc_cnt_r;
    // Qualified short run length; too long for a repetition
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) sc_cnt_r <= 0;
        else if (short_in[0] && conv_enabled[0]) sc_cnt_r <= sc_cnt_r + 1;
        else sc_cnt_r <= 0;
    end
    sequence s_hot; thermal_sd_in [*5]; endsequence
    sequence s_ovp; supply_ov_in [*5]; endsequence
    AST_WAIT_ONE: assert property (!avs_waitrequest |=> avs_waitrequest)
        else $error("waitrequest low longer than one cycle");
    AST_ANSWER: assert property ((avs_read || avs_write) |-> ##[0:2] !avs_waitrequest)
        else $error("bus request not answered");
    AST_TSD_OFF: assert property (s_hot |-> ##[0:2] (all_conv_off && !irq_out_n))
        else $error("thermal shutdown not acted on");
    AST_OVP_OFF: assert property (s_ovp |-> ##[0:2] (gpo_force_low && !irq_out_n))
        else $error("supply overvoltage not acted on");
    AST_GPO_EQ: assert property (gpo_force_low == all_conv_off)
        else $error("outputs low and converters off disagree");
    AST_UVLO: assert property (uvlo_in [*4] |-> ##[0:2] device_restart)
        else $error("lockout did not restart device");
    AST_SHORT: assert property (sc_cnt_r == SC_CYCLES + 6 |-> conv_short_off[0])
        else $error("short did not disable converter");
    AST_STICKY: assert property (conv_short_off[0] && !avs_write && !$past(avs_write)
        && !$past(avs_write, 2) && !uvlo_in && !$past(uvlo_in) && !$past(uvlo_in, 2)
        && !$past(uvlo_in, 3) |=> conv_short_off[0])
        else $error("short disable dropped without a clear");
    AST_MON_OFF: assert property (!conv_enabled[0] |-> ##[0:2] !monitor_enable_reg[0])
        else $error("monitor of stopped converter still enabled");
endmodule

bind sdi_top sdi_checker #(.SC_CYCLES(SC_CYCLES)) u_chk (.*);
`default_nettype wire

// ==== testbench/sdi_host_model.sv ====
// Host model: register bus master
`default_nettype none
module sdi_host_model (
    // Clock
    input  wire logic        clock,
    // Register bus
    output var  logic [7:0]  avs_address,
    output var  logic        avs_read,
    output var  logic        avs_write,
    output var  logic [31:0] avs_writedata,
    output var  logic [3:0]  avs_byteenable,
    input  wire logic [31:0] avs_readdata,
    input  wire logic        avs_waitrequest
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        avs_address = 8'h00;
        avs_read = 1'b0;
        avs_write = 1'b0;
        avs_writedata = 32'h0000_0000;
        avs_byteenable = 4'h0;
    end
    // Idle lines show inverse values, never stale ones
    task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d,
                        output logic [31:0] q);
        @(posedge clock);
        avs_address <= a;
        avs_writedata <= d;
        avs_byteenable <= 4'hF;
        avs_write <= wr;
        avs_read <= !wr;
        do @(posedge clock); while (avs_waitrequest !== 1'b0);
        q = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        avs_address <= ~a;
        avs_writedata <= ~d;
        avs_byteenable <= 4'h0;
    endtask
endmodule
`default_nettype wire

// ==== testbench/tb_top.sv ====
// Testbench of the supply diagnostic block
`include "sdi_consts.svh"
`default_nettype none
module tb_top;
    import sdi_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int SC = 20;
    logic clock, sys_rst, avs_read, avs_write, avs_waitrequest;
    logic [7:0] avs_address;
    logic [31:0] avs_writedata, avs_readdata;
    logic [3:0] avs_byteenable;
    logic [1:0] step_down_ilim_in = 2'h0;
    logic [5:0] rail_under_in = 6'h00, rail_over_in = 6'h00, monitor_enable_reg;
    logic sync_clk_present_in = 1'b0, step_up_ilim_in, thermal_warn_in, thermal_sd_in;
    logic supply_ov_in, uvlo_in, meas_done, irq_out_n, all_conv_off, gpo_force_low;
    logic device_restart, ov_uv_select, analog_supply_nominal_sel;
    logic [2:0] short_in, conv_enabled, conv_short_off;
    logic [1:0] step_up_nominal_sel;
    sdi_band_t step_down_band_sel_0, step_down_band_sel_1, step_up_band_sel;
    sdi_band_t ext_monitor_band_sel_a, ext_monitor_band_sel_b;
    sdi_ana_band_t analog_supply_band_sel;
    logic [3:0] ext_monitor_nominal_sel_a, ext_monitor_nominal_sel_b;
    int n_mismatch = 0, n_compared = 0, cyc = 0;
    sdi_top #(.ILIM_CYCLES(8), .SC_CYCLES(SC)) dut (.*);
    sdi_host_model host (.*);
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_compared++;
        if (g !== e) begin
            n_mismatch++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        host.xfer(1'b1, a, d, q);
    endtask
    task automatic chk_rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
        logic [31:0] q;
        host.xfer(1'b0, a, 32'h0000_0000, q);
        chk($sformatf("reg %h", a), e, q & m);
    endtask
    task automatic t_defaults();
        logic [7:0] ofs[6] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h18};
        chk("irq_out_n", 32'h0000_0001, 32'(irq_out_n));
        wr(8'h18, 32'hFFFF_FFFF);
        foreach (ofs[k]) chk_rd(ofs[k], 32'h0000_0000, 32'hFFFF_FFFF);
        $display("test defaults done");
    endtask
    task automatic t_config();
        @(posedge clock);
        conv_enabled <= 3'h7;
        wr(`SDI_OFS_CFG, 32'h0000_007F);
        wr(`SDI_OFS_LEVEL, 32'h006C_85DB);
        chk_rd(`SDI_OFS_LEVEL, 32'h006C_85DB, 32'hFFFF_FFFF);
        chk("selects", {2'h0, 1'h1, 6'h3F, 2'h3, 2'h2, 2'h1, 2'h3, 1'h1, 2'h2, 4'h0, 4'h9,
            2'h1, 2'h3}, 32'({ov_uv_select, monitor_enable_reg, step_down_band_sel_0,
            step_down_band_sel_1, step_up_nominal_sel, step_up_band_sel,
            analog_supply_nominal_sel, analog_supply_band_sel, ext_monitor_nominal_sel_a,
            ext_monitor_nominal_sel_b, ext_monitor_band_sel_a, ext_monitor_band_sel_b}));
        conv_enabled <= 3'h0;
        repeat (3) @(posedge clock);
        chk("monitor_enable_reg", 32'h0000_0038, 32'(monitor_enable_reg));
        wr(`SDI_OFS_CFG, 32'h0000_0000);
        $display("test config done");
    endtask
    // Step-up limit, warning, shutdown, overvoltage; first two maskable
    task automatic t_event();
        logic [31:0] f;
        for (int i = 0; i < 4; i++) begin
            f = 32'h0000_0001 << ((i == 0) ? `SDI_F_UP_ILIM : `SDI_F_TWARN + i - 1);
            for (int m = 0; m < ((i < 2) ? 2 : 1); m++) begin
                wr(`SDI_OFS_MASK, m ? f : 32'h0000_0000);
                {supply_ov_in, thermal_sd_in, thermal_warn_in, step_up_ilim_in} <= 4'h1 << i;
                repeat (16) @(posedge clock);
                chk("irq_out_n", 32'(m), 32'(irq_out_n));
                chk("safe_off", (i > 1) ? 32'h0000_0003 : 32'h0000_0000,
                    32'({all_conv_off, gpo_force_low}));
                wr(`SDI_OFS_FLAGS, f);
                chk_rd(`SDI_OFS_FLAGS, f, 32'h0003_FFFF);
                {supply_ov_in, thermal_sd_in, thermal_warn_in, step_up_ilim_in} <= 4'h0;
                repeat (4) @(posedge clock);
                wr(`SDI_OFS_FLAGS, f);
                repeat (3) @(posedge clock);
                chk("idle", 32'h0000_0001, 32'({all_conv_off, gpo_force_low, irq_out_n}));
            end
        end
        wr(`SDI_OFS_MASK, 32'h0000_0000);
        $display("test events done");
    endtask
    task automatic t_short();
        for (int i = 0; i < 2; i++) begin
            @(posedge clock);
            conv_enabled <= 3'h7;
            short_in <= i ? 3'h4 : 3'h1;
            repeat (SC + 10) @(posedge clock);
            chk("conv_short_off", i ? 32'h0000_0004 : 32'h0000_0001, 32'(conv_short_off));
            chk_rd(`SDI_OFS_FLAGS, 32'h0000_0001 << (i ? `SDI_F_UP_SC : `SDI_F_DN_SC),
                32'h0003_FFFF);
            short_in <= 3'h0;
            wr(`SDI_OFS_FLAGS, 32'h0000_0028);
            repeat (3) @(posedge clock);
            chk("idle", 32'h0000_0001, 32'({conv_short_off, irq_out_n}));
        end
        $display("test short done");
    endtask
    task automatic t_reset();
        for (int i = 0; i < 2; i++) begin
            @(posedge clock);
            meas_done <= 1'b1;
            @(posedge clock);
            meas_done <= 1'b0;
            chk_rd(`SDI_OFS_FLAGS, 32'h0001_0000, 32'h0003_FFFF);
            wr(`SDI_OFS_LEVEL, 32'h0000_0055);
            if (i) wr(`SDI_OFS_CFG, 32'h0000_0100);
            else begin
                uvlo_in <= 1'b1;
                repeat (10) @(posedge clock);
                uvlo_in <= 1'b0;
            end
            repeat (6) @(posedge clock);
            chk("irq_out_n", 32'h0000_0000, 32'(irq_out_n));
            chk_rd(`SDI_OFS_FLAGS, 32'h0002_0000, 32'h0003_FFFF);
            chk_rd(`SDI_OFS_LEVEL, 32'h0000_0000, 32'hFFFF_FFFF);
            wr(`SDI_OFS_FLAGS, 32'h0002_0000);
        end
        $display("test reset done");
    endtask
    task automatic t_rails();
        wr(`SDI_OFS_CFG, 32'h0000_00A0);
        {sync_clk_present_in, rail_under_in[4], step_down_ilim_in[0]} <= 3'h7;
        repeat (16) @(posedge clock);
        chk_rd(`SDI_OFS_STATUS, 32'h0000_8001, 32'h0000_FFFF);
        chk_rd(`SDI_OFS_FLAGS, 32'h0014_A001, 32'h001F_FFFF);
        {sync_clk_present_in, rail_under_in[4], step_down_ilim_in[0]} <= 3'h0;
        repeat (8) @(posedge clock);
        wr(`SDI_OFS_FLAGS, 32'h0003_FFFF);
        repeat (3) @(posedge clock);
        chk("irq_out_n", 32'h0000_0001, 32'(irq_out_n));
        $display("test rails done");
    endtask
    task automatic summarize();
        $display("compared %0d mismatched %0d", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    initial begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end
    // Whole run needs a few hundred cycles
    always @(posedge clock) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            n_mismatch++;
            summarize();
        end
    end
    initial begin
        sys_rst = 1'b1;
        {step_up_ilim_in, thermal_warn_in, thermal_sd_in, supply_ov_in} = 4'h0;
        {uvlo_in, meas_done, short_in, conv_enabled} = 8'h00;
        repeat (8) @(posedge clock);
        sys_rst <= 1'b0;
        t_defaults();
        t_config();
        t_event();
        t_short();
        t_reset();
        t_rails();
        summarize();
    end
endmodule
`default_nettype wire
